// *** inc/flag_bank_if.sv ***
`timescale 1ns/1ps
interface flag_bank_if;
  logic [11:0] exceeded;
  logic        read_strobe;
  logic [11:0] flags;
  modport owner (input exceeded, input read_strobe, output flags);
  modport user  (output exceeded, output read_strobe, input flags);
endinterface : flag_bank_if

// *** inc/limit_flag_map.svh ***
`ifndef LIMIT_FLAG_MAP_SVH
`define LIMIT_FLAG_MAP_SVH
`define LOW_LIMIT_FLAG_STATUS_ADDR  10'h008
`define HIGH_LIMIT_FLAG_STATUS_ADDR 10'h009
`define LIMIT_FLAG_RESET            12'h000
`define UNUSED_BITS_VALUE           4'h0
`define STAGE_COUNT                 12
`define RDATA_IDLE                  16'h0000
`define IRQ_IDLE                    1'b1
`endif

// *** inc/limit_flag_pkg.sv ***
package limit_flag_pkg;
  typedef logic [11:0] stage_vec_t;
  typedef logic [15:0] reg_word_t;
endpackage : limit_flag_pkg

// *** verification/host_model.sv ***
`timescale 1ns/1ps
module host_model(input wire logic ref_clk,output logic [9:0] reg_addr,
output logic reg_read,input wire logic [15:0] reg_rdata);
initial begin reg_addr=0; reg_read=0; end
task rd(input logic [9:0] a,output logic [15:0] d);
  @(posedge ref_clk) begin reg_addr<=a; reg_read<=1; end
  @(posedge ref_clk) reg_read<=0;
  @(negedge ref_clk) d=reg_rdata;
endtask : rd
endmodule : host_model

// *** verification/lim_chk.sv ***
`timescale 1ns/1ps
module lim_chk(input wire logic ref_clk,rst_b,reg_read,irq_b,
input wire logic [11:0] low_exceeded,high_exceeded,stage_upper_limit_irq_gate,
input wire logic [9:0] reg_addr,input wire logic [15:0] reg_rdata);
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_b);
top_zero_a: assert property (reg_rdata[15:12]==0) else $error("top");
low_set_a: assert property (low_exceeded[0] ##1 !reg_read ##1 reg_read&&reg_addr==10'h008
|=> reg_rdata[0]) else $error("low");
high_set_a: assert property (high_exceeded[11] ##1 !reg_read ##1 reg_read&&reg_addr==10'h009
|=> reg_rdata[11]) else $error("high");
read_clear_a: assert property (reg_read&&reg_addr==10'h008&&!low_exceeded[0]
##1 !low_exceeded[0] ##1 reg_read&&reg_addr==10'h008 |=> !reg_rdata[0]) else $error("clr");
irq_on_a: assert property ((high_exceeded[8]&&stage_upper_limit_irq_gate[8])[*3]
|=> !irq_b) else $error("irq on");
irq_off_a: assert property ((stage_upper_limit_irq_gate==0)[*2] |=> irq_b) else $error("off");
endmodule : lim_chk
bind touch_limit_irq_status lim_chk chk(.ref_clk(ref_clk),.rst_b(rst_b),.reg_read(reg_read),
.irq_b(irq_b),.low_exceeded(low_exceeded),.high_exceeded(high_exceeded),
.stage_upper_limit_irq_gate(stage_upper_limit_irq_gate),.reg_addr(reg_addr),.reg_rdata(reg_rdata));

// *** verification/touch_limit_irq_status_tb.sv ***
`timescale 1ns/1ps
module touch_limit_irq_status_tb;
logic ref_clk=0,rst_b=0,reg_read,irq_b; logic [11:0] lo=0,hi=0,gate=0;
logic [9:0] reg_addr; logic [15:0] reg_rdata,d; int mismatches=0,total_checks=0,cyc=0;
touch_limit_irq_status DUT(.ref_clk,.rst_b,.low_exceeded(lo),.high_exceeded(hi),
.stage_upper_limit_irq_gate(gate),.reg_addr,.reg_read,.reg_rdata,.irq_b);
host_model h(.ref_clk,.reg_addr,.reg_read,.reg_rdata);
initial forever #20 ref_clk=~ref_clk;
always @(posedge ref_clk) if(++cyc>400) begin mismatches++; end_of_test; end
task chk(input logic [15:0] g,e); total_checks++;
if(g!==e) begin mismatches++; $display("ERROR %0t %h %h",$time,g,e); end endtask : chk
task chk_irq(input logic g,e); total_checks++;
if(g!==e) begin mismatches++; $display("ERROR %0t %h %h",$time,g,e); end endtask : chk_irq
task rc(input logic [9:0] a,input logic [15:0] e); h.rd(a,d); chk(d,e); endtask : rc
task end_of_test; $display("mismatches=%0d total_checks=%0d",mismatches,total_checks);
if(mismatches==0&&total_checks>0) $display("TEST PASSED"); else $display("TEST FAILED");
$finish; endtask : end_of_test
initial begin
  repeat(10) @(posedge ref_clk); rst_b<=1;
  rc(10'h008,16'h0000);
  @(posedge ref_clk) begin lo<=12'h801; hi<=12'hfff; gate<=12'h100; end
  @(posedge ref_clk) begin lo<=0; hi<=12'h100; end
  rc(10'h008,16'h0801);
  rc(10'h008,16'h0000);
  rc(10'h00A,16'h0000);
  rc(10'h009,16'h0fff);
  rc(10'h009,16'h0100);
  chk_irq(irq_b,1'b0);
  @(posedge ref_clk) gate<=0;
  repeat(3) @(negedge ref_clk);
  chk_irq(irq_b,1'b1);
  @(posedge ref_clk) lo<=12'hfff;
  @(posedge ref_clk) lo<=0;
  @(posedge ref_clk) rst_b<=0;
  repeat(2) @(posedge ref_clk); rst_b<=1;
  rc(10'h008,16'h0000);
  end_of_test;
end
endmodule : touch_limit_irq_status_tb

// *** verilog/flag_bank.sv ***
`timescale 1ns/1ps
`include "limit_flag_map.svh"
module flag_bank
  import limit_flag_pkg::*;
(
  input wire logic   ref_clk,
  input wire logic   rst_b,
  flag_bank_if.owner bank
);
  stage_vec_t flag_q;
  stage_vec_t next_flag;

  // Set wins over the read clear, so a crossing in the read cycle survives
  genvar n;
  generate
    for (n = 0; n < `STAGE_COUNT; n++) begin : g_stage
      assign next_flag[n] = bank.exceeded[n] | (flag_q[n] & ~bank.read_strobe);
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= `LIMIT_FLAG_RESET;
    end else begin
      flag_q <= next_flag;
    end
  end

  assign bank.flags = flag_q;
endmodule : flag_bank

// *** verilog/touch_limit_irq_status.sv ***
`timescale 1ns/1ps
`include "limit_flag_map.svh"
module touch_limit_irq_status
  import limit_flag_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [11:0] low_exceeded,
  input  wire logic [11:0] high_exceeded,
  input  wire logic [11:0] stage_upper_limit_irq_gate,
  input  wire logic [9:0]  reg_addr,
  input  wire logic        reg_read,
  output      logic [15:0] reg_rdata,
  output      logic        irq_b
);
  // One bank per limit, so both registers behave identically
  flag_bank_if low_bank ();
  flag_bank_if high_bank ();

  // Answer tracker states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ANSWER = 2'b10
  } answer_state_t;

  // Exact compare; any other address reads zero and clears nothing
  function automatic logic addr_match(
    input logic [9:0] addr,
    input logic [9:0] target
  );
    addr_match = (addr == target);
  endfunction : addr_match

  // Top nibble forced here so no stale bits can leak out
  function automatic reg_word_t pack_word(
    input stage_vec_t flags
  );
    pack_word = {`UNUSED_BITS_VALUE, flags};
  endfunction : pack_word

  // One interrupt source: a set high flag behind an open gate
  function automatic logic irq_source(
    input logic flag,
    input logic gate
  );
    irq_source = flag & gate;
  endfunction : irq_source

  // Register select
  wire logic sel_low;
  wire logic sel_high;
  wire logic hit_low;
  wire logic hit_high;
  wire logic hit_any;

  assign sel_low  = addr_match(reg_addr, `LOW_LIMIT_FLAG_STATUS_ADDR);
  assign sel_high = addr_match(reg_addr, `HIGH_LIMIT_FLAG_STATUS_ADDR);
  assign hit_low  = reg_read & sel_low;
  assign hit_high = reg_read & sel_high;
  assign hit_any  = hit_low | hit_high;

  // Comparator levels enter directly: they share this clock
  assign low_bank.exceeded     = low_exceeded;
  assign low_bank.read_strobe  = hit_low;
  assign high_bank.exceeded    = high_exceeded;
  assign high_bank.read_strobe = hit_high;

  flag_bank u_low (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .bank    (low_bank)
  );

  flag_bank u_high (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .bank    (high_bank)
  );

  // Per-stage view of both banks and of the interrupt sources
  stage_vec_t low_view;
  stage_vec_t high_view;
  stage_vec_t irq_src;

  genvar s;
  generate
    for (s = 0; s < `STAGE_COUNT; s++) begin : g_stage
      assign low_view[s]  = low_bank.flags[s];
      assign high_view[s] = high_bank.flags[s];
      assign irq_src[s]   = irq_source(high_bank.flags[s],
                                       stage_upper_limit_irq_gate[s]);
    end
  endgenerate

  // End stages named, so the bit order is easy to check on a trace
  wire logic stage_zero_low_flag;
  wire logic stage_eleven_low_flag;
  wire logic stage_zero_high_flag;
  wire logic stage_eleven_high_flag;

  assign stage_zero_low_flag    = low_view[0];
  assign stage_eleven_low_flag  = low_view[11];
  assign stage_zero_high_flag   = high_view[0];
  assign stage_eleven_high_flag = high_view[11];

  // Stage n lands on bit n
  wire stage_vec_t low_ordered;
  wire stage_vec_t high_ordered;

  assign low_ordered  = {stage_eleven_low_flag, low_view[10:1],
                         stage_zero_low_flag};
  assign high_ordered = {stage_eleven_high_flag, high_view[10:1],
                         stage_zero_high_flag};

  // Readback selection
  wire reg_word_t low_word;
  wire reg_word_t high_word;
  wire reg_word_t picked_word;
  wire reg_word_t next_rdata;

  assign low_word    = pack_word(low_ordered);
  assign high_word   = pack_word(high_ordered);
  assign picked_word = hit_high ? high_word : low_word;

  // Idle cycles read as zero, so old data is never replayed
  assign next_rdata  = hit_any ? picked_word : `RDATA_IDLE;

  // Interrupt combine
  wire logic irq_any;
  wire logic next_irq_b;

  // Low-limit flags never raise the pin; only gated high flags do
  assign irq_any    = |irq_src;
  assign next_irq_b = ~irq_any;

  // Answer tracker: read data reloads on every read cycle and on the cycle after the last read cycle, while in the answer state
  answer_state_t state_q;
  answer_state_t next_state;
  wire logic     load_rdata;

  always_comb begin
    case (state_q)
      ST_IDLE: begin
        next_state = hit_any ? ST_ANSWER : ST_IDLE;
      end
      ST_ANSWER: begin
        next_state = hit_any ? ST_ANSWER : ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Any state but idle reloads, so a corrupted state still clears the data
  assign load_rdata = hit_any | (state_q != ST_IDLE);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= next_state;
    end
  end

  // Read data register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `RDATA_IDLE;
    end else if (load_rdata) begin
      reg_rdata <= next_rdata;
    end
  end

  // Registered so the pin never glitches while flags settle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_b <= `IRQ_IDLE;
    end else begin
      irq_b <= next_irq_b;
    end
  end
endmodule : touch_limit_irq_status
